/* hdl/vpo_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Every output word changes on the rising edge of the internal output clock.
// - The width pin picks 10-bit or 20-bit output, apart from transport mode.
// - Format pins are inputs in slave mode, driven status outputs in master mode.
// - While reset is low the data, format and output clock pins are high impedance; irq and the register slave are driven.
// - With standard definition selected the output clock pin is inverted.
// - SMPTE 20-bit: luma on lanes 19..10, chroma on lanes 9..0.
// - SMPTE 10-bit: multiplexed words on lanes 19..10, lanes 9..0 held low.
// - Transport mode forces 10-bit output whatever the width pin says.
// - Transport byte sits on lanes 17..10, most significant bit on lane 17.
// - Transport mode: lane 19 carries sync detected, lane 18 code word error.
// - Transport mode holds lanes 9..0 low.
// - Data-through passes raw data with no decode, descramble or alignment.
// - Master mode with no timing reference nor sync found drives all lanes low.
// - Data-through exists only in slave mode, chosen by the format pins.
// - SD output clock: wide rate for 20-bit, double rate for 10-bit.
// - HD output clock: wide rate for 20-bit, double rate for 10-bit.
// - Transport output always uses the 10-bit clock rate.
// - Video high transport low is SMPTE; reverse is transport; both low data-through.
// - Data-through: both halves at 20-bit, upper half only with lower low at 10-bit.
module vpo_formatter (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] lumaWord,
	input wire logic [9:0] chromaWord,
	input wire logic [9:0] muxWord,
	input wire logic [19:0] rawWord,
	input wire logic [7:0] transportByte,
	input wire logic syncDetectedFlag,
	input wire logic codeWordErrorFlag,
	input wire logic trsFound,
	input wire logic detectedSd,
	input wire logic outputWidthSelect,
	input wire logic definitionRateSelectIn,
	output logic definitionRateSelectOut,
	output logic definitionRateSelectOe,
	input wire logic videoProcessingSelectIn,
	output logic videoProcessingSelectOut,
	output logic videoProcessingSelectOe,
	input wire logic transportModeSelectIn,
	output logic transportModeSelectOut,
	output logic transportModeSelectOe,
	output logic [19:0] dout,
	output logic doutOe,
	output logic pclk,
	output logic pclkOe,
	output logic irq
);
	typedef struct packed {
		logic [19:0] dout;
		logic doutOe;
		logic pclkLvl;
		logic pclk;
		logic pclkOe;
		logic [2:0] fmtOut;
		logic fmtOe;
		logic [1:0] ctrl;
		logic [2:0] irqStat;
		logic [2:0] irqEn;
		logic irq;
		vpo_pkg::vpo_mode_t modePrev;
		vpo_pkg::vpo_wr_state_t wrState;
		logic awready;
		logic wready;
		logic awHeld;
		logic wHeld;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vpo_top_st_t;

	vpo_top_st_t s, n;
	logic [3:0] pinSync;
	logic genLvl;
	logic genRise;
	logic master;
	logic sdEff;
	logic wideEff;
	vpo_pkg::vpo_mode_t modeEff;
	logic [2:0] evt;
	logic [2:0] clr;

	// Pins from the far side pass two flops first
	vpo_sync2 #(
		.W(4)
	) vpo_sync2_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d({transportModeSelectIn, videoProcessingSelectIn, definitionRateSelectIn,
			outputWidthSelect}),
		.q(pinSync)
	);

	// Output clock divider, rate set by effective width
	vpo_pclk_gen vpo_pclk_gen_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wide(wideEff),
		.lvl(genLvl),
		.rise(genRise)
	);

	// Format resolution, lane mapping, interrupts and the register slave
	always_comb begin
		n = s;
		evt = '0;
		clr = '0;
		master = s.ctrl[vpo_pkg::CTRL_MASTER];
		// Master follows the detector; slave obeys the pins
		if (master) begin
			sdEff = detectedSd;
			if (trsFound) begin
				modeEff = vpo_pkg::MODE_SMPTE;
			end else if (syncDetectedFlag) begin
				modeEff = vpo_pkg::MODE_ASI;
			end else begin
				modeEff = vpo_pkg::MODE_NONE;
			end
		end else begin
			sdEff = pinSync[1];
			case (pinSync[3:2])
				2'b01: modeEff = vpo_pkg::MODE_SMPTE;
				2'b10: modeEff = vpo_pkg::MODE_ASI;
				2'b00: modeEff = vpo_pkg::MODE_THRU;
				default: modeEff = vpo_pkg::MODE_NONE;
			endcase
		end
		// Transport ignores the width pin
		wideEff = pinSync[0] && (modeEff != vpo_pkg::MODE_ASI);

		// Format pins: driven only as master status
		n.fmtOe = master;
		n.fmtOut = {modeEff == vpo_pkg::MODE_ASI, modeEff == vpo_pkg::MODE_SMPTE, sdEff};

		// Pin clock inverted in SD for extra hold margin at the receiver
		n.pclkLvl = genLvl;
		n.pclk = genLvl ^ sdEff;
		n.pclkOe = 1'b1;
		n.doutOe = s.ctrl[vpo_pkg::CTRL_OUT_EN];

		// New word only at the rising output clock edge
		if (genRise) begin
			case (modeEff)
				vpo_pkg::MODE_SMPTE: begin
					if (wideEff) begin
						n.dout = {lumaWord, chromaWord};
					end else begin
						n.dout = {muxWord, 10'h000};
					end
				end
				vpo_pkg::MODE_ASI: begin
					n.dout = {syncDetectedFlag, codeWordErrorFlag, transportByte, 10'h000};
				end
				vpo_pkg::MODE_THRU: begin
					if (wideEff) begin
						n.dout = rawWord;
					end else begin
						n.dout = {rawWord[19:10], 10'h000};
					end
				end
				default: begin
					n.dout = 20'h00000;
				end
			endcase
			n.modePrev = modeEff;
			evt[vpo_pkg::IRQ_MODE_CHG] = modeEff != s.modePrev;
			evt[vpo_pkg::IRQ_WORD_ERR] = (modeEff == vpo_pkg::MODE_ASI) && codeWordErrorFlag;
			evt[vpo_pkg::IRQ_NO_SYNC] = (modeEff == vpo_pkg::MODE_NONE) &&
				(s.modePrev != vpo_pkg::MODE_NONE);
		end

		// Write channel: address and data taken in either order
		if (s.awready && s_axi_awvalid) begin
			n.awHeld = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			n.wHeld = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		case (s.wrState)
			vpo_pkg::WS_COLLECT: begin
				if (s.awHeld && s.wHeld) begin
					n.awHeld = 1'b0;
					n.wHeld = 1'b0;
					n.bvalid = 1'b1;
					n.bresp = vpo_pkg::RESP_OKAY;
					n.wrState = vpo_pkg::WS_RESP;
					case (s.awaddr)
						vpo_pkg::REG_CTRL: begin
							if (s.wstrb[0]) begin
								n.ctrl = s.wdata[1:0];
							end
						end
						vpo_pkg::REG_IRQ_CLR: begin
							if (s.wstrb[0]) begin
								clr = s.wdata[2:0];
							end
						end
						vpo_pkg::REG_IRQ_EN: begin
							if (s.wstrb[0]) begin
								n.irqEn = s.wdata[2:0];
							end
						end
						vpo_pkg::REG_STATUS, vpo_pkg::REG_IRQ_STAT: begin
							n.bresp = vpo_pkg::RESP_OKAY; // Read-only, write dropped
						end
						default: begin
							n.bresp = vpo_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			vpo_pkg::WS_RESP: begin
				if (s_axi_bready) begin
					n.bvalid = 1'b0;
					n.wrState = vpo_pkg::WS_COLLECT;
				end
			end
			default: begin
				n.wrState = vpo_pkg::WS_COLLECT;
			end
		endcase
		n.awready = !n.awHeld && (n.wrState == vpo_pkg::WS_COLLECT);
		n.wready = !n.wHeld && (n.wrState == vpo_pkg::WS_COLLECT);

		// Read channel: data with the address handshake edge
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s.arready && s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = vpo_pkg::RESP_OKAY;
			case (s_axi_araddr)
				vpo_pkg::REG_CTRL: n.rdata = {30'h00000000, s.ctrl};
				vpo_pkg::REG_STATUS: n.rdata = {27'h0000000, master, wideEff, sdEff, modeEff};
				vpo_pkg::REG_IRQ_STAT: n.rdata = {29'h00000000, s.irqStat};
				vpo_pkg::REG_IRQ_EN: n.rdata = {29'h00000000, s.irqEn};
				default: begin
					n.rdata = 32'h00000000;
					n.rresp = vpo_pkg::RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;

		// Sticky status: a new event beats a clear in the same cycle
		n.irqStat = (s.irqStat & ~clr) | evt;
		n.irq = |(n.irqStat & n.irqEn);
	end

	// All state on one async-reset register; reset releases the data, clock and format pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.ctrl <= vpo_pkg::CTRL_RESET;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign definitionRateSelectOut = s.fmtOut[0];
	assign videoProcessingSelectOut = s.fmtOut[1];
	assign transportModeSelectOut = s.fmtOut[2];
	assign definitionRateSelectOe = s.fmtOe;
	assign videoProcessingSelectOe = s.fmtOe;
	assign transportModeSelectOe = s.fmtOe;
	assign dout = s.dout;
	assign doutOe = s.doutOe;
	assign pclk = s.pclk;
	assign pclkOe = s.pclkOe;
	assign irq = s.irq;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_LAUNCH_EDGE: assert property ($changed(s.dout) |-> $rose(s.pclkLvl))
		else $error("output word changed away from a rising clock edge");
	AST_SMPTE_WIDE: assert property (genRise && modeEff == vpo_pkg::MODE_SMPTE && wideEff
		|=> s.dout == {$past(lumaWord), $past(chromaWord)})
		else $error("luma or chroma on wrong lanes");
	AST_SMPTE_NARROW: assert property (genRise && modeEff == vpo_pkg::MODE_SMPTE && !wideEff
		|=> s.dout[19:10] == $past(muxWord) && s.dout[9:0] == 10'h000)
		else $error("multiplexed word misplaced or low lanes not low");
	AST_ASI_LANES: assert property (genRise && modeEff == vpo_pkg::MODE_ASI
		|=> s.dout == {$past(syncDetectedFlag), $past(codeWordErrorFlag), $past(transportByte),
			10'h000})
		else $error("transport lanes mapped wrongly");
	AST_ASI_NARROW: assert property (modeEff == vpo_pkg::MODE_ASI |-> !wideEff)
		else $error("transport mode left at 20-bit");
	AST_THRU_LANES: assert property (genRise && modeEff == vpo_pkg::MODE_THRU
		|=> s.dout[19:10] == $past(rawWord[19:10]) &&
			s.dout[9:0] == ($past(wideEff) ? $past(rawWord[9:0]) : 10'h000))
		else $error("raw data lanes wrong");
	AST_NO_SYNC_LOW: assert property (genRise && master && !trsFound && !syncDetectedFlag
		|=> s.dout == 20'h00000)
		else $error("bus not low without sync in master mode");
	AST_MASTER_NO_THRU: assert property (master |-> modeEff != vpo_pkg::MODE_THRU)
		else $error("data-through reached in master mode");
	AST_FMT_DRIVE: assert property ($changed(s.ctrl[vpo_pkg::CTRL_MASTER])
		|=> s.fmtOe == $past(s.ctrl[vpo_pkg::CTRL_MASTER]))
		else $error("format pin direction does not follow master mode");
	AST_SD_INVERT: assert property (s.pclk == (s.pclkLvl ^ $past(sdEff)))
		else $error("output clock polarity wrong for rate");
	AST_BVALID_HOLD: assert property (s.bvalid && !s_axi_bready |=> s.bvalid)
		else $error("write response dropped before ready");

	CVR_SMPTE_WIDE: cover property (genRise && modeEff == vpo_pkg::MODE_SMPTE && wideEff);
	CVR_ASI: cover property (genRise && modeEff == vpo_pkg::MODE_ASI && codeWordErrorFlag);
	CVR_THRU_NARROW: cover property (genRise && modeEff == vpo_pkg::MODE_THRU && !wideEff);
	CVR_IRQ: cover property ($rose(s.irq));
endmodule : vpo_formatter
`default_nettype wire

/* hdl/vpo_pclk_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module vpo_pclk_gen (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wide,
	output logic lvl,
	output logic rise
);
	typedef struct packed {
		logic [1:0] cnt;
		logic lvl;
		logic rise;
	} vpo_pclk_st_t;

	vpo_pclk_st_t s, n;

	// Divider; the half period is reloaded at each toggle so a width change never glitches
	always_comb begin
		n = s;
		n.rise = 1'b0;
		if (s.cnt <= 2'h1) begin
			n.cnt = wide ? vpo_pkg::HALF_WIDE : vpo_pkg::HALF_NARROW;
			n.lvl = ~s.lvl;
			n.rise = ~s.lvl;
		end else begin
			n.cnt = s.cnt - 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign lvl = s.lvl;
	assign rise = s.rise;

	AST_NARROW_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.rise && (s.cnt == 2'h1) && !wide |=> !s.rise ##1 s.rise)
		else $error("narrow output clock period is not two cycles");
	AST_RISE_SPACING: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.rise |=> !s.rise)
		else $error("output clock rose twice in a row");
endmodule : vpo_pclk_gen
`default_nettype wire

/* hdl/vpo_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module vpo_sync2 #(
	parameter int W = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} vpo_sync_st_t;

	vpo_sync_st_t s, n;

	// First stage feeds only the second
	always_comb begin
		n = s;
		n.s1 = d;
		n.s2 = s.s1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.s2;
endmodule : vpo_sync2
`default_nettype wire

/* include/vpo_pkg.sv */
`default_nettype none
package vpo_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam int ADDR_W = 8;

	// Control fields and reset value (drivers enabled, slave mode)
	localparam int CTRL_OUT_EN = 0;
	localparam int CTRL_MASTER = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	// Status fields
	localparam int ST_MODE_LSB = 0;
	localparam int ST_SD = 2;
	localparam int ST_WIDE = 3;
	localparam int ST_MASTER = 4;

	// Interrupt event bits
	localparam int IRQ_MODE_CHG = 0;
	localparam int IRQ_WORD_ERR = 1;
	localparam int IRQ_NO_SYNC = 2;
	localparam int IRQ_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Lane geometry
	localparam int LANE_W = 10;
	localparam int BUS_W = 20;
	localparam int ASI_W = 8;

	// Output clock half period in core cycles; 10-bit runs twice the 20-bit rate
	localparam logic [1:0] HALF_WIDE = 2'h2;
	localparam logic [1:0] HALF_NARROW = 2'h1;

	typedef enum logic [1:0] {
		MODE_SMPTE = 2'b00,
		MODE_ASI = 2'b01,
		MODE_THRU = 2'b10,
		MODE_NONE = 2'b11
	} vpo_mode_t;

	typedef enum logic [0:0] {
		WS_COLLECT = 1'b0,
		WS_RESP = 1'b1
	} vpo_wr_state_t;
endpackage : vpo_pkg
`default_nettype wire

/* tb/video_parallel_output_formatter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module video_parallel_output_formatter_test;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [9:0] lumaWord = 10'h2a5, chromaWord = 10'h15a, muxWord = 10'h3c3;
	logic [19:0] rawWord = 20'h9a5c3;
	logic [7:0] transportByte = 8'hb4;
	logic syncDetectedFlag = 1'h1, codeWordErrorFlag = 1'h0, trsFound = 1'h0;
	logic detectedSd = 1'h0, outputWidthSelect = 1'h1;
	logic [2:0] drv = 3'h2;
	logic [2:0] fmtWire, fmtOut, fmtOe;
	logic [19:0] dout, capWord;
	logic doutOe, pclk, pclkOe, irq;
	int capCnt;
	int mismatches = 0;
	int numChecks = 0;
	logic [31:0] rd;
	logic [1:0] rr;

	vpo_formatter vpo_formatter_inst (
		.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lumaWord, .chromaWord, .muxWord,
		.rawWord, .transportByte, .syncDetectedFlag, .codeWordErrorFlag, .trsFound,
		.detectedSd, .outputWidthSelect,
		.definitionRateSelectIn(fmtWire[0]), .definitionRateSelectOut(fmtOut[0]),
		.definitionRateSelectOe(fmtOe[0]), .videoProcessingSelectIn(fmtWire[1]),
		.videoProcessingSelectOut(fmtOut[1]), .videoProcessingSelectOe(fmtOe[1]),
		.transportModeSelectIn(fmtWire[2]), .transportModeSelectOut(fmtOut[2]),
		.transportModeSelectOe(fmtOe[2]), .dout, .doutOe, .pclk, .pclkOe, .irq
	);

	vpo_rx_model vpo_rx_model_inst (
		.drv, .fmtOut, .fmtOe, .fmtWire, .pclk, .pclkOe, .dout, .doutOe, .capWord, .capCnt
	);

	// 20 MHz core clock
	initial begin
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		if (mismatches == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic hang;
		mismatches++;
		$display("[ERR] %0t wait ran out", $time);
		complete_run();
	endtask : hang

	// Write with both channels offered together; bready held until the answer
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) hang();
		s_axi_bready <= 1'h0;
		check(s_axi_bresp, er);
	endtask : axiWr

	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) hang();
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axiRd

	task automatic waitCaps(input int k);
		int c0;
		c0 = capCnt;
		for (int n = 0; n < 100 && capCnt < c0 + k; n++) @(posedge core_clk);
		if (capCnt < c0 + k) hang();
	endtask : waitCaps

	// Flip the words, find the edge where the bus moves, then time one clock period
	task automatic clkCheck(input int per, input logic sd);
		int n;
		int ch;
		logic [19:0] old;
		logic lvl;
		old = dout;
		lumaWord <= ~lumaWord;
		chromaWord <= ~chromaWord;
		muxWord <= ~muxWord;
		rawWord <= ~rawWord;
		transportByte <= ~transportByte;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			#1;
			if (dout !== old) break;
		end
		if (n == 20) hang();
		check(pclk, !sd);
		lvl = pclk;
		ch = 0;
		for (n = 1; n < 20; n++) begin
			@(posedge core_clk);
			#1;
			if (pclk !== lvl) begin
				lvl = pclk;
				ch++;
				if (ch == 2) break;
			end
		end
		check(n, per);
	endtask : clkCheck

	task automatic videoCase(input logic [2:0] pins, input logic wide, input int per);
		@(posedge core_clk);
		drv <= pins;
		outputWidthSelect <= wide;
		waitCaps(4);
	endtask : videoCase

	task automatic scenRegs;
		axiRd(vpo_pkg::REG_CTRL, rd, rr);
		check(rd, 32'h1);
		axiRd(8'h40, rd, rr);
		check(rd, 32'h0);
		check(rr, vpo_pkg::RESP_SLVERR);
		axiWr(8'h40, 32'h3, vpo_pkg::RESP_SLVERR);
		axiRd(vpo_pkg::REG_IRQ_CLR, rd, rr);
		check(rr, vpo_pkg::RESP_SLVERR);
		axiRd(vpo_pkg::REG_STATUS, rd, rr);
		check(rd, 32'h8);
	endtask : scenRegs

	task automatic scenSmpte;
		videoCase(3'h2, 1'h1, 4);
		check(capWord, {lumaWord, chromaWord});
		clkCheck(4, 1'h0);
		videoCase(3'h2, 1'h0, 2);
		check(capWord, {muxWord, 10'h0});
		clkCheck(2, 1'h0);
		videoCase(3'h3, 1'h1, 4);
		check(capWord, {lumaWord, chromaWord});
		clkCheck(4, 1'h1);
		videoCase(3'h3, 1'h0, 2);
		check(capWord, {muxWord, 10'h0});
		clkCheck(2, 1'h1);
	endtask : scenSmpte

	task automatic scenThrough;
		videoCase(3'h0, 1'h1, 4);
		check(capWord, rawWord);
		clkCheck(4, 1'h0);
		videoCase(3'h1, 1'h0, 2);
		check(capWord, {rawWord[19:10], 10'h0});
		clkCheck(2, 1'h1);
	endtask : scenThrough

	task automatic scenAsi;
		videoCase(3'h5, 1'h1, 2);
		check(capWord, {2'h2, transportByte, 10'h0});
		clkCheck(2, 1'h1);
		@(posedge core_clk);
		syncDetectedFlag <= 1'h0;
		codeWordErrorFlag <= 1'h1;
		videoCase(3'h5, 1'h0, 2);
		check(capWord, {2'h1, transportByte, 10'h0});
	endtask : scenAsi

	// Word error event: masked, then enabled, then cleared
	task automatic scenIrq;
		axiRd(vpo_pkg::REG_IRQ_STAT, rd, rr);
		check({rd[1], irq}, 2'h2);
		axiWr(vpo_pkg::REG_IRQ_EN, 32'h2, vpo_pkg::RESP_OKAY);
		repeat (2) @(posedge core_clk);
		check(irq, 1'h1);
		codeWordErrorFlag <= 1'h0;
		waitCaps(2);
		axiWr(vpo_pkg::REG_IRQ_CLR, 32'h2, vpo_pkg::RESP_OKAY);
		repeat (2) @(posedge core_clk);
		check(irq, 1'h0);
	endtask : scenIrq

	task automatic scenMaster;
		@(posedge core_clk);
		syncDetectedFlag <= 1'h0;
		drv <= 3'h2;
		outputWidthSelect <= 1'h1;
		axiWr(vpo_pkg::REG_CTRL, 32'h3, vpo_pkg::RESP_OKAY);
		waitCaps(4);
		check(capWord, 20'h0);
		check(fmtOe, 3'h7);
		trsFound <= 1'h1;
		waitCaps(4);
		check({fmtWire, capWord}, {3'h2, lumaWord, chromaWord});
		axiWr(vpo_pkg::REG_CTRL, 32'h1, vpo_pkg::RESP_OKAY);
		repeat (2) @(posedge core_clk);
		check(fmtOe, 3'h0);
	endtask : scenMaster

	// Reset held 12 cycles, outputs checked while it is held
	initial begin
		repeat (6) @(posedge core_clk);
		check({doutOe, pclkOe, fmtOe}, 5'h0);
		repeat (6) @(posedge core_clk);
		rst_n <= 1'h1;
		scenRegs();
		check({doutOe, pclkOe, fmtOe}, 5'h18);
		scenSmpte();
		scenThrough();
		scenAsi();
		scenIrq();
		scenMaster();
		complete_run();
	end
endmodule : video_parallel_output_formatter_test
`default_nettype wire

/* tb/vpo_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Receiving logic beside the output bus, also owning the format pins in slave mode
module vpo_rx_model (
	input wire logic [2:0] drv,
	input wire logic [2:0] fmtOut,
	input wire logic [2:0] fmtOe,
	output logic [2:0] fmtWire,
	input wire logic pclk,
	input wire logic pclkOe,
	input wire logic [19:0] dout,
	input wire logic doutOe,
	output logic [19:0] capWord,
	output int capCnt
);
	logic effClk;

	// Pins let go once the device drives them, so master mode sees no contention
	assign fmtWire = (fmtOe & fmtOut) | (~fmtOe & drv);

	// Undo the SD inversion, then sample mid-word for the widest hold margin
	assign effClk = pclk ^ fmtWire[0];

	initial capCnt = 0;

	// Capture; a released bus shows the inverse so a missing drive is caught
	always @(negedge effClk) begin
		if (pclkOe) begin
			capWord <= doutOe ? dout : ~dout;
			capCnt <= capCnt + 1;
		end
	end
endmodule : vpo_rx_model
`default_nettype wire
